// ===== pkg/fcsp_cfg.svh
`ifndef FCSP_CFG_SVH
`define FCSP_CFG_SVH

`define FCSP_OFF_MODE0 8'h60
`define FCSP_OFF_CMD0 8'h64
`define FCSP_OFF_STAT0 8'h68
`define FCSP_OFF_MODE1 8'h70
`define FCSP_OFF_CMD1 8'h74
`define FCSP_OFF_STAT1 8'h78

`define FCSP_KEY 8'h5a
`define FCSP_KEY_HI 31
`define FCSP_KEY_LO 24
`define FCSP_PAGE_HI 17
`define FCSP_PAGE_LO 8
`define FCSP_OP_HI 3
`define FCSP_OP_LO 0

`define FCSP_OP_NONE 4'h0
`define FCSP_OP_WP 4'h1
`define FCSP_OP_SLB 4'h2
`define FCSP_OP_WPL 4'h3
`define FCSP_OP_CLB 4'h4
`define FCSP_OP_EA 4'h8
`define FCSP_OP_SET_USER_NV_BIT_CMD 4'hb
`define FCSP_OP_CLEAR_USER_NV_BIT_CMD 4'hd
`define FCSP_OP_SSB 4'hf

`define FCSP_ST_RDY 0
`define FCSP_ST_LERR 2
`define FCSP_ST_BERR 3
`define FCSP_ST_SEC 4
`define FCSP_ST_NV_LO 8
`define FCSP_ST_LOCK_LO 16
`define FCSP_MODE_RDY_IE 0

`define FCSP_CLK_NS 10
`define FCSP_OP_NS 640
`define FCSP_OP_CYCLES ((`FCSP_OP_NS + `FCSP_CLK_NS - 1) / `FCSP_CLK_NS)

`endif

// ===== pkg/fcsp_pkg.sv
`default_nettype none
package fcsp_pkg;
	typedef enum logic [1:0] {
		fcsp_idle = 2'b00,
		fcsp_run = 2'b01,
		fcsp_lock = 2'b10
	} fcsp_state_t;
endpackage : fcsp_pkg
`default_nettype wire

// ===== core/fcsp_port.sv
`include "fcsp_cfg.svh"
`default_nettype none
module fcsp_port
	import fcsp_pkg::*;
#(
	parameter int NUM_REGIONS = 16,
	parameter int PAGE_W = 10,
	parameter int NV_BITS = 3,
	parameter int OP_CYCLES = `FCSP_OP_CYCLES,
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);

	// ****************************************
	// elaboration checks
	// ****************************************
	localparam int RSH = PAGE_W - $clog2(NUM_REGIONS);

	if (NUM_REGIONS > 16 || NUM_REGIONS < 2 || (NUM_REGIONS & (NUM_REGIONS - 1)) != 0)
		$error("NUM_REGIONS must be a power of two from 2 to 16");
	if (PAGE_W > 10 || RSH < 0)
		$error("PAGE_W must fit the page field and cover all regions");
	if (NV_BITS < 1 || NV_BITS > 3)
		$error("NV_BITS must be 1 to 3");
	if (OP_CYCLES < 1 || OP_CYCLES >= (1 << CNT_W))
		$error("OP_CYCLES does not fit CNT_W");

	localparam logic [CNT_W-1:0] OP_LOAD = CNT_W'(OP_CYCLES - 1);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] region_of(input logic [9:0] page);
		logic [9:0] sh;
		sh = page >> RSH;
		return sh[3:0];
	endfunction : region_of

	function automatic logic [7:0] cmd_off(input int i);
		return (i == 0) ? `FCSP_OFF_CMD0 : `FCSP_OFF_CMD1;
	endfunction : cmd_off

	function automatic logic [7:0] stat_off(input int i);
		return (i == 0) ? `FCSP_OFF_STAT0 : `FCSP_OFF_STAT1;
	endfunction : stat_off

	function automatic logic [7:0] mode_off(input int i);
		return (i == 0) ? `FCSP_OFF_MODE0 : `FCSP_OFF_MODE1;
	endfunction : mode_off

	function automatic logic op_defined(input logic [3:0] op);
		return op == `FCSP_OP_NONE || op == `FCSP_OP_WP || op == `FCSP_OP_SLB || op == `FCSP_OP_WPL
			|| op == `FCSP_OP_CLB || op == `FCSP_OP_EA || op == `FCSP_OP_SET_USER_NV_BIT_CMD || op == `FCSP_OP_CLEAR_USER_NV_BIT_CMD
			|| op == `FCSP_OP_SSB;
	endfunction : op_defined

	// ****************************************
	// state
	// ****************************************
	fcsp_state_t state_reg [2];
	fcsp_state_t state_next [2];
	logic [CNT_W-1:0] cnt_reg [2];
	logic [CNT_W-1:0] cnt_next [2];
	logic [3:0] op_reg [2];
	logic [3:0] op_next [2];
	logic [9:0] page_reg [2];
	logic [9:0] page_next [2];
	logic [15:0] lock_reg [2];
	logic [15:0] lock_next [2];
	logic [2:0] nv_reg;
	logic [2:0] nv_next;
	logic sec_reg;
	logic sec_next;
	logic [1:0] lerr_reg;
	logic [1:0] lerr_next;
	logic [1:0] berr_reg;
	logic [1:0] berr_next;
	logic [1:0] ie_reg;
	logic [1:0] ie_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic irq_reg;
	logic irq_next;

	// ****************************************
	// bus decode
	// ****************************************
	logic access;
	logic answer;
	logic [1:0] cmd_hit;
	logic [1:0] stat_rd;
	logic [1:0] mode_wr;
	logic [1:0] done;
	logic mapped;
	logic [31:0] rd_val;
	logic [7:0] key;
	logic [3:0] opcode;
	logic [9:0] page;

	assign key = pwdata[`FCSP_KEY_HI:`FCSP_KEY_LO];
	assign opcode = pwdata[`FCSP_OP_HI:`FCSP_OP_LO];
	// with NUM_REGIONS at 16, unused high page bits drop out in region_of; the nv range check counts them, so they put the page out of range
	assign page = pwdata[`FCSP_PAGE_HI:`FCSP_PAGE_LO];

	// one wait state: the answer is registered, so prdata is a flop
	assign answer = psel & penable & ~pready_reg;
	assign access = psel & penable & pready_reg;

	always_comb begin
		mapped = 1'b0;
		rd_val = 32'h0000_0000;
		cmd_hit = 2'b00;
		stat_rd = 2'b00;
		mode_wr = 2'b00;
		for (int i = 0; i < 2; i++) begin
			cmd_hit[i] = access & pwrite & (paddr == cmd_off(i));
			stat_rd[i] = access & ~pwrite & (paddr == stat_off(i));
			mode_wr[i] = access & pwrite & (paddr == mode_off(i));
			if (paddr == cmd_off(i) || paddr == mode_off(i) || paddr == stat_off(i)) begin
				mapped = 1'b1;
			end
			if (paddr == mode_off(i)) begin
				rd_val[`FCSP_MODE_RDY_IE] = ie_reg[i];
			end
			if (paddr == stat_off(i)) begin
				rd_val[`FCSP_ST_RDY] = (state_reg[i] == fcsp_idle);
				rd_val[`FCSP_ST_LERR] = lerr_reg[i];
				rd_val[`FCSP_ST_BERR] = berr_reg[i];
				rd_val[`FCSP_ST_LOCK_LO +: 16] = lock_reg[i];
				if (i == 0) begin
					rd_val[`FCSP_ST_SEC] = sec_reg;
					rd_val[`FCSP_ST_NV_LO +: 3] = nv_reg;
				end
			end
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	always_comb begin
		pready_next = answer;
		pslverr_next = answer & ~mapped;
		prdata_next = prdata_reg;
		if (answer) begin
			prdata_next = pwrite ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// ****************************************
	// command sequencers, one per controller
	// ****************************************
	always_comb begin
		nv_next = nv_reg;
		sec_next = sec_reg;
		done = 2'b00;
		for (int i = 0; i < 2; i++) begin
			state_next[i] = state_reg[i];
			cnt_next[i] = cnt_reg[i];
			op_next[i] = op_reg[i];
			page_next[i] = page_reg[i];
			lock_next[i] = lock_reg[i];
			lerr_next[i] = lerr_reg[i];
			berr_next[i] = berr_reg[i];
			ie_next[i] = ie_reg[i];
			// clear only what the answered read showed, so a later set survives
			if (stat_rd[i]) begin
				lerr_next[i] = lerr_reg[i] & ~prdata_reg[`FCSP_ST_LERR];
				berr_next[i] = berr_reg[i] & ~prdata_reg[`FCSP_ST_BERR];
			end
			if (mode_wr[i]) begin
				ie_next[i] = pwdata[`FCSP_MODE_RDY_IE];
			end
			if (cmd_hit[i]) begin
				if (key != `FCSP_KEY) begin
					berr_next[i] = 1'b1;
				end else if (!op_defined(opcode)) begin
					berr_next[i] = 1'b1;
				end else if (state_reg[i] == fcsp_idle && opcode != `FCSP_OP_NONE) begin
					if ((opcode == `FCSP_OP_WP || opcode == `FCSP_OP_WPL) && lock_reg[i][region_of(page)]) begin
						lerr_next[i] = 1'b1;
					end else if (opcode == `FCSP_OP_EA && |lock_reg[i]) begin
						state_next[i] = fcsp_idle;
					end else begin
						state_next[i] = fcsp_run;
						cnt_next[i] = OP_LOAD;
						op_next[i] = opcode;
						page_next[i] = page;
					end
				end
			end
			unique case (state_reg[i])
				fcsp_idle: begin
				end
				fcsp_run: begin
					if (cnt_reg[i] != '0) begin
						cnt_next[i] = cnt_reg[i] - 1'b1;
					end else begin
						state_next[i] = fcsp_idle;
						done[i] = 1'b1;
						// page programming and erase act on the array, not on state held here
						unique case (op_reg[i])
							`FCSP_OP_WPL: begin
								state_next[i] = fcsp_lock;
								cnt_next[i] = OP_LOAD;
								done[i] = 1'b0;
							end
							`FCSP_OP_SLB: lock_next[i][region_of(page_reg[i])] = 1'b1;
							`FCSP_OP_CLB: lock_next[i][region_of(page_reg[i])] = 1'b0;
							`FCSP_OP_SET_USER_NV_BIT_CMD: begin
								if (i == 0 && page_reg[i] < 10'(NV_BITS)) begin
									nv_next[page_reg[i][1:0]] = 1'b1;
								end
							end
							`FCSP_OP_CLEAR_USER_NV_BIT_CMD: begin
								if (i == 0 && page_reg[i] < 10'(NV_BITS)) begin
									nv_next[page_reg[i][1:0]] = 1'b0;
								end
							end
							`FCSP_OP_SSB: begin
								if (i == 0) begin
									sec_next = 1'b1;
								end
							end
							default: begin
							end
						endcase
					end
				end
				fcsp_lock: begin
					if (cnt_reg[i] != '0) begin
						cnt_next[i] = cnt_reg[i] - 1'b1;
					end else begin
						lock_next[i][region_of(page_reg[i])] = 1'b1;
						state_next[i] = fcsp_idle;
						done[i] = 1'b1;
					end
				end
				default: begin
					state_next[i] = fcsp_idle;
				end
			endcase
		end
		// cleared by any status read; a completion in the same cycle wins
		irq_next = (|(done & ie_reg)) | (irq_reg & ~|stat_rd);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2; i++) begin
				state_reg[i] <= fcsp_idle;
				cnt_reg[i] <= '0;
				op_reg[i] <= 4'h0;
				page_reg[i] <= 10'h000;
				lock_reg[i] <= 16'h0000;
			end
			nv_reg <= 3'h0;
			sec_reg <= 1'b0;
			lerr_reg <= 2'h0;
			berr_reg <= 2'h0;
			ie_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				state_reg[i] <= state_next[i];
				cnt_reg[i] <= cnt_next[i];
				op_reg[i] <= op_next[i];
				page_reg[i] <= page_next[i];
				lock_reg[i] <= lock_next[i];
			end
			nv_reg <= nv_next;
			sec_reg <= sec_next;
			lerr_reg <= lerr_next;
			berr_reg <= berr_next;
			ie_reg <= ie_next;
			irq_reg <= irq_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	// ****************************************
	// assertions, primary controller
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic good0;
	assign good0 = cmd_hit[0] && key == `FCSP_KEY;

	// busy age counter: a long delay range would be unrolled, a counter bounds the busy time cheaply
	localparam logic [CNT_W+1:0] BUSY_MAX = (CNT_W+2)'(2 * OP_CYCLES);
	logic [CNT_W+1:0] busy_age_reg;
	logic [CNT_W+1:0] busy_age_next;

	always_comb begin
		busy_age_next = '0;
		if (state_reg[0] != fcsp_idle) begin
			busy_age_next = busy_age_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_age_reg <= '0;
		end else begin
			busy_age_reg <= busy_age_next;
		end
	end

	sequence s_wpl_prog_end;
		state_reg[0] == fcsp_run && op_reg[0] == `FCSP_OP_WPL && cnt_reg[0] == '0;
	endsequence

	sequence s_wpl_lock_end;
		state_reg[0] == fcsp_lock && cnt_reg[0] == '0;
	endsequence

	a_bad_key_flag: assert property (cmd_hit[0] && key != `FCSP_KEY |=> berr_reg[0] && $stable(state_reg[0]))
		else $error("wrong key not flagged or not ignored");
	a_bad_op_flag: assert property (good0 && !op_defined(opcode) |=> berr_reg[0] && $stable(state_reg[0]))
		else $error("reserved opcode not flagged");
	a_null_quiet: assert property (good0 && opcode == `FCSP_OP_NONE && !stat_rd[0]
		|=> $stable(berr_reg[0]) && $stable(state_reg[0]))
		else $error("null command had an effect");
	a_ready_drop: assert property (good0 && opcode == `FCSP_OP_WP && state_reg[0] == fcsp_idle
		&& !lock_reg[0][region_of(page)] |=> state_reg[0] == fcsp_run)
		else $error("ready did not drop");
	a_busy_bound: assert property (busy_age_reg <= BUSY_MAX)
		else $error("ready never returned");
	a_locked_write: assert property (good0 && opcode == `FCSP_OP_WP && state_reg[0] == fcsp_idle
		&& lock_reg[0][region_of(page)] |=> lerr_reg[0] && state_reg[0] == fcsp_idle)
		else $error("program of locked region not refused");
	a_erase_cancel: assert property (good0 && opcode == `FCSP_OP_EA && state_reg[0] == fcsp_idle
		&& |lock_reg[0] |=> state_reg[0] == fcsp_idle)
		else $error("erase-all not cancelled");
	a_lock_set: assert property (state_reg[0] == fcsp_run && op_reg[0] == `FCSP_OP_SLB && cnt_reg[0] == '0
		|=> lock_reg[0][region_of(page_reg[0])] && state_reg[0] == fcsp_idle)
		else $error("lock command did not lock region");
	a_lock_clear: assert property (state_reg[0] == fcsp_run && op_reg[0] == `FCSP_OP_CLB && cnt_reg[0] == '0
		|=> !lock_reg[0][region_of(page_reg[0])])
		else $error("unlock command did not unlock region");
	a_wpl_chain: assert property (s_wpl_prog_end |=> state_reg[0] == fcsp_lock)
		else $error("program-and-lock did not go on to lock");
	a_wpl_lock: assert property (s_wpl_lock_end |=> lock_reg[0][region_of(page_reg[0])] && state_reg[0] == fcsp_idle)
		else $error("program-and-lock did not lock");
	a_nv_range: assert property (state_reg[0] == fcsp_run && op_reg[0] == `FCSP_OP_SET_USER_NV_BIT_CMD && cnt_reg[0] == '0
		&& page_reg[0] >= 10'(NV_BITS) |=> $stable(nv_reg))
		else $error("out of range nv bit changed");
	a_secure_set: assert property (state_reg[0] == fcsp_run && op_reg[0] == `FCSP_OP_SSB && cnt_reg[0] == '0
		|=> sec_reg)
		else $error("security bit not set");
	a_irq_ready: assert property (done[0] && ie_reg[0] |=> irq_reg && state_reg[0] == fcsp_idle)
		else $error("ready interrupt missing");
	a_read_clear: assert property (stat_rd[0] && prdata_reg[`FCSP_ST_BERR] && !cmd_hit[0] |=> !berr_reg[0])
		else $error("bad command flag not cleared by read");

endmodule : fcsp_port
`default_nettype wire

// ===== dv/fcsp_port_tb.sv
`include "fcsp_cfg.svh"
`default_nettype none
module fcsp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// signals
	// ********
	localparam logic [7:0] m0 = `FCSP_OFF_MODE0;
	localparam logic [7:0] c0 = `FCSP_OFF_CMD0;
	localparam logic [7:0] s0 = `FCSP_OFF_STAT0;
	localparam logic [7:0] c1 = `FCSP_OFF_CMD1;
	localparam logic [7:0] s1 = `FCSP_OFF_STAT1;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] rd;
	logic er;
	int miscompares = 0;
	int check_count = 0;

	always #5 pclk = ~pclk;

	// short op time keeps the run brief; 8 leaves room for a second write while busy
	fcsp_port #(.OP_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));

	// ********
	// tasks
	// ********
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// one edge always passes before a new setup, so no strobe is assigned twice in a step
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count is assumed here: only the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic cmd(input logic [7:0] a, input logic [3:0] op, input logic [9:0] pg);
		bus(1'b1, a, {`FCSP_KEY, 6'h00, pg, 4'h0, op});
	endtask : cmd

	task automatic st(input logic [7:0] a, input string what, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(what, rd, exp);
	endtask : st

	// polling reads clear the flags, so callers never expect a flag across it
	task automatic wait_rdy(input logic [7:0] a);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h00000000);
			n++;
		end while (rd[0] !== 1'b1 && n < 40);
		if (n >= 40) begin
			miscompares++;
			close_out();
		end
	endtask : wait_rdy

	// ********
	// scenarios
	// ********
	task automatic t_reset();
		check("irq after reset", {31'h0, irq}, 32'h0);
		st(s0, "status0 after reset", 32'h00000001);
		st(s1, "status1 after reset", 32'h00000001);
		st(c0, "command reads zero", 32'h00000000);
		bus(1'b0, 8'h6c, 32'h00000000);
		check("unmapped error", {31'h0, er}, 32'h1);
	endtask : t_reset

	task automatic t_lock();
		cmd(c0, `FCSP_OP_SLB, 10'h07f);
		cmd(c0, `FCSP_OP_SLB, 10'h000);
		st(s0, "busy during lock", 32'h00000000);
		wait_rdy(s0);
		st(s0, "region 1 locked only", 32'h00020001);
	endtask : t_lock

	task automatic t_prog();
		cmd(c0, `FCSP_OP_WP, 10'h040);
		st(s0, "locked write flag", 32'h00020005);
		st(s0, "locked flag cleared", 32'h00020001);
		cmd(c0, `FCSP_OP_WP, 10'h000);
		st(s0, "program busy", 32'h00020000);
		wait_rdy(s0);
		cmd(c0, `FCSP_OP_CLB, 10'h041);
		wait_rdy(s0);
		st(s0, "region 1 unlocked", 32'h00000001);
	endtask : t_prog

	task automatic t_wpl();
		cmd(c0, `FCSP_OP_WPL, 10'h3c5);
		repeat (8) @(posedge pclk);
		st(s0, "lock follows program", 32'h00000000);
		wait_rdy(s0);
		st(s0, "region 15 locked", 32'h80000001);
	endtask : t_wpl

	task automatic t_erase();
		cmd(c0, `FCSP_OP_EA, 10'h000);
		st(s0, "erase cancelled", 32'h80000001);
		cmd(c0, `FCSP_OP_CLB, 10'h3ff);
		wait_rdy(s0);
		cmd(c0, `FCSP_OP_EA, 10'h155);
		st(s0, "erase running", 32'h00000000);
		wait_rdy(s0);
		st(s0, "erase done", 32'h00000001);
	endtask : t_erase

	task automatic t_nv();
		logic [3:0] ops[4] = '{`FCSP_OP_SET_USER_NV_BIT_CMD, `FCSP_OP_SET_USER_NV_BIT_CMD, `FCSP_OP_SET_USER_NV_BIT_CMD, `FCSP_OP_CLEAR_USER_NV_BIT_CMD};
		logic [9:0] pgs[4] = '{10'h000, 10'h002, 10'h003, 10'h000};
		for (int i = 0; i < 4; i++) begin
			cmd(c0, ops[i], pgs[i]);
			wait_rdy(s0);
		end
		st(s0, "nv bits", 32'h00000401);
		cmd(c0, `FCSP_OP_SSB, 10'h3ff);
		wait_rdy(s0);
		st(s0, "security bit", 32'h00000411);
	endtask : t_nv

	task automatic t_second();
		cmd(c1, `FCSP_OP_SLB, 10'h000);
		wait_rdy(s1);
		cmd(c1, `FCSP_OP_SET_USER_NV_BIT_CMD, 10'h001);
		wait_rdy(s1);
		cmd(c1, `FCSP_OP_SSB, 10'h000);
		wait_rdy(s1);
		st(s1, "second status", 32'h00010001);
		st(s0, "first untouched", 32'h00000411);
	endtask : t_second

	task automatic t_bad();
		logic [3:0] rsv[7] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hc, 4'he};
		bus(1'b1, c0, 32'h5b000002);
		st(s0, "bad key flag", 32'h00000419);
		st(s0, "bad flag cleared", 32'h00000411);
		foreach (rsv[i]) begin
			cmd(c0, rsv[i], 10'h000);
			st(s0, "reserved opcode", 32'h00000419);
		end
		bus(1'b1, c0, 32'h00000002);
		cmd(c0, `FCSP_OP_NONE, 10'h000);
		st(s0, "opcode zero keeps flag", 32'h00000419);
		cmd(c0, `FCSP_OP_NONE, 10'h000);
		st(s0, "opcode zero raises nothing", 32'h00000411);
	endtask : t_bad

	task automatic t_irq();
		bus(1'b1, m0, 32'h00000001);
		st(m0, "ready irq enable readback", 32'h00000001);
		cmd(c0, `FCSP_OP_SLB, 10'h000);
		check("irq while busy", {31'h0, irq}, 32'h0);
		repeat (12) @(posedge pclk);
		check("irq on done", {31'h0, irq}, 32'h1);
		st(s0, "status after irq", 32'h00010411);
		@(posedge pclk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		bus(1'b1, m0, 32'h00000000);
	endtask : t_irq

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lock();
		t_prog();
		t_wpl();
		t_erase();
		t_nv();
		t_second();
		t_bad();
		t_irq();
		close_out();
	end

	initial begin
		#200us;
		miscompares++;
		close_out();
	end
endmodule : fcsp_port_tb
`default_nettype wire
